/* core/irb_ctrl.sv */
// input route selection and battery sense control, two-wire slave
// assumes open-drain data resolved outside; comparator flags async
`timescale 1ns/10ps
module irb_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // two-wire serial port
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  // comparator results from the sense pins
  input wire logic battery_sense_pin_a,
  input wire logic battery_sense_pin_b,
  // analog controls and interrupt request
  output irb_pkg::irb_route_t route_q,
  output irb_pkg::irb_sense_ctrl_t sense_a_ctrl_q,
  output irb_pkg::irb_sense_ctrl_t sense_b_ctrl_q,
  output logic interrupt_request_pin
);
  import irb_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic sa_m_q, sa_s_q, sb_m_q, sb_s_q;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  irb_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, tx_q, sub_q, rd_data;
  logic rw_q, mack_q, wr_pulse;
  logic [4:0] fmt_q;
  logic [1:0] stat_q;
  logic [1:0] clr_req;

  // reset release through two flops
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // pin synchronisers plus a history stage for edges
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      {sa_m_q, sa_s_q, sb_m_q, sb_s_q} <= 4'h0;
    end
    else
    begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_pin, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_pin_in, sda_m_q, sda_s_q};
      {sa_m_q, sa_s_q} <= {battery_sense_pin_a, sa_m_q};
      {sb_m_q, sb_s_q} <= {battery_sense_pin_b, sb_m_q};
    end
  end

  // bus events
  assign scl_rise = scl_s_q && !scl_p_q;
  assign scl_fall = !scl_s_q && scl_p_q;
  assign start_ev = scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
  assign stop_ev = scl_s_q && scl_p_q && sda_s_q && !sda_p_q;
  assign wr_pulse = scl_fall && (state_q == IRB_ST_WR)
    && (cnt_q == IRB_BYTE_BITS);

  // read mux, reserved bits and unmapped offsets read zero
  always_comb
  begin
    rd_data = 8'h00;
    unique case (sub_q)
      IRB_OFS_INPUT_FORMAT_SELECT: rd_data[IRB_FMT_MSB:0] = fmt_q;
      IRB_OFS_DIAG_PIN_A_CONTROL:
      begin
        rd_data[IRB_PWRDN_BIT] = sense_a_ctrl_q.powerdown;
        rd_data[IRB_THR_MSB:IRB_THR_LSB] = sense_a_ctrl_q.threshold;
      end
      IRB_OFS_DIAG_PIN_B_CONTROL:
      begin
        rd_data[IRB_PWRDN_BIT] = sense_b_ctrl_q.powerdown;
        rd_data[IRB_THR_MSB:IRB_THR_LSB] = sense_b_ctrl_q.threshold;
      end
      IRB_OFS_SENSE_STATUS: rd_data[1:0] = stat_q;
      default: rd_data = 8'h00;
    endcase
  end

  // serial slave sequencer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= IRB_ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      sub_q <= 8'h00;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      sda_pin_oe <= 1'b0;
    end
    else if (start_ev)
    begin
      state_q <= IRB_ST_ADDR;
      cnt_q <= 4'h0;
      sda_pin_oe <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_q <= IRB_ST_IDLE;
      sda_pin_oe <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (state_q == IRB_ST_RD_ACK)
        mack_q <= !sda_s_q;
      else if (state_q inside {IRB_ST_ADDR, IRB_ST_SUB, IRB_ST_WR,
                               IRB_ST_RD})
      begin
        shift_q <= {shift_q[6:0], sda_s_q};
        cnt_q <= cnt_q + 4'h1;
      end
    end
    else if (scl_fall)
    begin
      unique case (state_q)
        IRB_ST_IDLE: state_q <= IRB_ST_IDLE;
        IRB_ST_ADDR:
          if (cnt_q == IRB_BYTE_BITS)
          begin
            if (shift_q[7:1] == IRB_DEV_ADDR)
            begin
              state_q <= IRB_ST_ADDR_ACK;
              rw_q <= shift_q[0];
              sda_pin_oe <= 1'b1; // pull low to acknowledge
            end
            else
              state_q <= IRB_ST_IDLE;
          end
        IRB_ST_ADDR_ACK:
        begin
          cnt_q <= 4'h0;
          if (rw_q)
          begin
            state_q <= IRB_ST_RD;
            tx_q <= rd_data;
            sda_pin_oe <= !rd_data[7];
          end
          else
          begin
            state_q <= IRB_ST_SUB;
            sda_pin_oe <= 1'b0;
          end
        end
        IRB_ST_SUB:
          if (cnt_q == IRB_BYTE_BITS)
          begin
            sub_q <= shift_q;
            state_q <= IRB_ST_SUB_ACK;
            sda_pin_oe <= 1'b1;
          end
        IRB_ST_SUB_ACK, IRB_ST_WR_ACK:
        begin
          state_q <= IRB_ST_WR;
          cnt_q <= 4'h0;
          sda_pin_oe <= 1'b0;
        end
        IRB_ST_WR:
          if (cnt_q == IRB_BYTE_BITS)
          begin
            sub_q <= sub_q + 8'h01; // auto increment
            state_q <= IRB_ST_WR_ACK;
            sda_pin_oe <= 1'b1;
          end
        IRB_ST_RD:
          if (cnt_q == IRB_BYTE_BITS)
          begin
            sub_q <= sub_q + 8'h01;
            state_q <= IRB_ST_RD_ACK;
            sda_pin_oe <= 1'b0;
          end
          else
          begin
            tx_q <= {tx_q[6:0], 1'b1};
            sda_pin_oe <= !tx_q[6];
          end
        IRB_ST_RD_ACK:
        begin
          cnt_q <= 4'h0;
          if (mack_q)
          begin
            state_q <= IRB_ST_RD;
            tx_q <= rd_data;
            sda_pin_oe <= !rd_data[7];
          end
          else
            state_q <= IRB_ST_IDLE;
        end
        default: state_q <= IRB_ST_IDLE;
      endcase
    end
  end

  // open-drain data only ever pulls low
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sda_pin_out <= 1'b0;
    else
      sda_pin_out <= 1'b0;
  end

  // format select register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fmt_q <= IRB_FMT_RESET;
    else if (wr_pulse && sub_q == IRB_OFS_INPUT_FORMAT_SELECT)
      fmt_q <= shift_q[IRB_FMT_MSB:0];
  end

  // sense control registers, powered down after reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sense_a_ctrl_q <= {IRB_PWRDN_RESET, IRB_THR_RESET};
      sense_b_ctrl_q <= {IRB_PWRDN_RESET, IRB_THR_RESET};
    end
    else if (wr_pulse)
    begin
      if (sub_q == IRB_OFS_DIAG_PIN_A_CONTROL)
      begin
        sense_a_ctrl_q.powerdown <= shift_q[IRB_PWRDN_BIT];
        sense_a_ctrl_q.threshold <= shift_q[IRB_THR_MSB:IRB_THR_LSB];
      end
      if (sub_q == IRB_OFS_DIAG_PIN_B_CONTROL)
      begin
        sense_b_ctrl_q.powerdown <= shift_q[IRB_PWRDN_BIT];
        sense_b_ctrl_q.threshold <= shift_q[IRB_THR_MSB:IRB_THR_LSB];
      end
    end
  end

  // routing decode, reserved codes power every channel down
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      route_q <= {IRB_VID_CVBS, IRB_PD_ONLY1};
    else
      unique case (fmt_q)
        IRB_CODE_CVBS1: route_q <= {IRB_VID_CVBS, IRB_PD_ONLY1};
        IRB_CODE_CVBS2: route_q <= {IRB_VID_CVBS, IRB_PD_ONLY2};
        IRB_CODE_CVBS3: route_q <= {IRB_VID_CVBS, IRB_PD_ONLY3};
        IRB_CODE_CVBS4: route_q <= {IRB_VID_CVBS, IRB_PD_ONLY4};
        IRB_CODE_YC12: route_q <= {IRB_VID_YC, IRB_PD_PAIR12};
        IRB_CODE_YC34: route_q <= {IRB_VID_YC, IRB_PD_PAIR34};
        IRB_CODE_DIFF12: route_q <= {IRB_VID_DIFF, IRB_PD_PAIR12};
        IRB_CODE_DIFF34: route_q <= {IRB_VID_DIFF, IRB_PD_PAIR34};
        default: route_q <= {IRB_VID_NONE, IRB_PD_ALL};
      endcase
  end

  // sticky short flags, write one to clear, new event wins
  assign clr_req = (wr_pulse && sub_q == IRB_OFS_SENSE_STATUS) ?
    shift_q[1:0] : 2'h0;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      stat_q <= 2'h0;
    else
      stat_q <= (stat_q & ~clr_req)
        | {sb_s_q && !sense_b_ctrl_q.powerdown,
           sa_s_q && !sense_a_ctrl_q.powerdown};
  end

  // interrupt pin follows any pending flag
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      interrupt_request_pin <= 1'b0;
    else
      interrupt_request_pin <= |stat_q;
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sense_a_sets_a: assert property ((sa_s_q && !sense_a_ctrl_q.powerdown)
    |=> stat_q[0]) else $error("pin a event lost");
  powered_only_a: assert property ($rose(stat_q[0])
    |-> !$past(sense_a_ctrl_q.powerdown))
    else $error("flag set while powered down");
  irq_raise_a: assert property ((stat_q != 2'h0) |=> interrupt_request_pin)
    else $error("interrupt not raised");
  irq_drop_a: assert property ((stat_q == 2'h0) |=> !interrupt_request_pin)
    else $error("interrupt without flag");
  status_read_a: assert property ((sub_q == IRB_OFS_SENSE_STATUS)
    |-> rd_data[1:0] == stat_q) else $error("status readback");
  fmt_write_a: assert property ((wr_pulse
    && sub_q == IRB_OFS_INPUT_FORMAT_SELECT)
    |=> fmt_q == $past(shift_q[4:0])) else $error("format write");
  cvbs_route_a: assert property ((fmt_q == IRB_CODE_CVBS3)
    |=> route_q.ain_powerdown == 4'hb) else $error("cvbs3 routing");
  diff_route_a: assert property ((fmt_q == IRB_CODE_DIFF34)
    |=> route_q == {IRB_VID_DIFF, 4'h3})
    else $error("diff34 routing");
  resv_route_a: assert property ((fmt_q == 5'h04) ##1 (fmt_q == 5'h04)
    |=> route_q.ain_powerdown == 4'hf) else $error("reserved code");
  pin_a_write_a: assert property ((wr_pulse
    && sub_q == IRB_OFS_DIAG_PIN_A_CONTROL)
    |=> sense_a_ctrl_q == {$past(shift_q[6]), $past(shift_q[4:2])})
    else $error("pin a control write");
  pin_b_write_a: assert property ((wr_pulse
    && sub_q == IRB_OFS_DIAG_PIN_B_CONTROL)
    |=> sense_b_ctrl_q == {$past(shift_q[6]), $past(shift_q[4:2])})
    else $error("pin b control write");

  write_seen_c: cover property (wr_pulse);
  read_seen_c: cover property (state_q == IRB_ST_RD_ACK && mack_q);
  short_b_c: cover property ($rose(stat_q[1]));
  clear_c: cover property (clr_req != 2'h0 ##1 stat_q == 2'h0);
endmodule : irb_ctrl

/* core/irb_pkg.sv */
// package for the input route and battery sense register bank
// assumes a two-wire serial host and one 250 MHz system clock
package irb_pkg;
  // serial bus
  localparam logic [6:0] IRB_DEV_ADDR = 7'h20;
  localparam logic [3:0] IRB_BYTE_BITS = 4'h8;
  // register offsets
  localparam logic [7:0] IRB_OFS_INPUT_FORMAT_SELECT = 8'h00;
  localparam logic [7:0] IRB_OFS_DIAG_PIN_A_CONTROL = 8'h5d;
  localparam logic [7:0] IRB_OFS_DIAG_PIN_B_CONTROL = 8'h5e;
  localparam logic [7:0] IRB_OFS_SENSE_STATUS = 8'h5f;
  // field positions
  localparam int IRB_FMT_MSB = 4;
  localparam int IRB_PWRDN_BIT = 6;
  localparam int IRB_THR_MSB = 4;
  localparam int IRB_THR_LSB = 2;
  // reset values
  localparam logic [4:0] IRB_FMT_RESET = 5'h00;
  localparam logic IRB_PWRDN_RESET = 1'h1;
  localparam logic [2:0] IRB_THR_RESET = 3'h3;
  // four-input format codes
  localparam logic [4:0] IRB_CODE_CVBS1 = 5'h00;
  localparam logic [4:0] IRB_CODE_CVBS2 = 5'h01;
  localparam logic [4:0] IRB_CODE_CVBS3 = 5'h06;
  localparam logic [4:0] IRB_CODE_CVBS4 = 5'h07;
  localparam logic [4:0] IRB_CODE_YC12 = 5'h08;
  localparam logic [4:0] IRB_CODE_YC34 = 5'h0b;
  localparam logic [4:0] IRB_CODE_DIFF12 = 5'h0e;
  localparam logic [4:0] IRB_CODE_DIFF34 = 5'h11;
  // channel power-down patterns, bit n is input n+1
  localparam logic [3:0] IRB_PD_ONLY1 = 4'he;
  localparam logic [3:0] IRB_PD_ONLY2 = 4'hd;
  localparam logic [3:0] IRB_PD_ONLY3 = 4'hb;
  localparam logic [3:0] IRB_PD_ONLY4 = 4'h7;
  localparam logic [3:0] IRB_PD_PAIR12 = 4'hc;
  localparam logic [3:0] IRB_PD_PAIR34 = 4'h3;
  localparam logic [3:0] IRB_PD_ALL = 4'hf;

  typedef enum logic [1:0] {
    IRB_VID_NONE = 2'b00,
    IRB_VID_CVBS = 2'b01,
    IRB_VID_YC = 2'b10,
    IRB_VID_DIFF = 2'b11
  } irb_video_t;

  typedef struct packed {
    irb_video_t video;
    logic [3:0] ain_powerdown;
  } irb_route_t;

  typedef struct packed {
    logic powerdown;
    logic [2:0] threshold;
  } irb_sense_ctrl_t;

  typedef enum logic [3:0] {
    IRB_ST_IDLE = 4'b0000,
    IRB_ST_ADDR = 4'b0001,
    IRB_ST_ADDR_ACK = 4'b0010,
    IRB_ST_SUB = 4'b0011,
    IRB_ST_SUB_ACK = 4'b0100,
    IRB_ST_WR = 4'b0101,
    IRB_ST_WR_ACK = 4'b0110,
    IRB_ST_RD = 4'b0111,
    IRB_ST_RD_ACK = 4'b1000
  } irb_state_t;
endpackage : irb_pkg

/* bench/irb_host_model.sv */
// two-wire bus master standing in for the system host controller
// assumes the testbench resolves the data line with a pull-up
`timescale 1ns/10ps
module irb_host_model (
  // system clock
  input wire logic clock,
  // bus lines
  input wire logic sda_wire,
  output logic scl_drv,
  output logic sda_drv
);
  // idle bus at time zero
  initial
  begin
    scl_drv = 1'h1;
    sda_drv = 1'h1;
  end

  // wait whole system clocks
  task automatic hwait(input int n);
    repeat (n) @(posedge clock);
  endtask : hwait

  // one bit, serial half period of 10 clocks
  task automatic xfer_bit(input logic b, output logic r);
    sda_drv <= b;
    hwait(5);
    scl_drv <= 1'h1;
    hwait(5);
    r = sda_wire;
    hwait(5);
    scl_drv <= 1'h0;
    hwait(5);
  endtask : xfer_bit

  // start, also used as repeated start
  task automatic start_cond();
    sda_drv <= 1'h1;
    hwait(5);
    scl_drv <= 1'h1;
    hwait(10);
    sda_drv <= 1'h0;
    hwait(10);
    scl_drv <= 1'h0;
    hwait(5);
  endtask : start_cond

  // stop leaves both lines released
  task automatic stop_cond();
    sda_drv <= 1'h0;
    hwait(5);
    scl_drv <= 1'h1;
    hwait(10);
    sda_drv <= 1'h1;
    hwait(10);
  endtask : stop_cond

  // eight bits msb first, then the ninth bit
  task automatic xfer_byte(input logic [7:0] d, input logic last,
                           output logic [7:0] r, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      xfer_bit(d[i], b);
      r = {r[6:0], b};
    end
    xfer_bit(last, ack);
  endtask : xfer_byte

  // register write; ok low when any byte went unanswered
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] data, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    start_cond();
    xfer_byte({dev, 1'h0}, 1'h1, r, a0);
    xfer_byte(ofs, 1'h1, r, a1);
    xfer_byte(data, 1'h1, r, a2);
    stop_cond();
    ok = !(a0 | a1 | a2);
  endtask : write_reg

  // register read with repeated start, single byte ended by nack
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
                          output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2, a3;
    start_cond();
    xfer_byte({dev, 1'h0}, 1'h1, r, a0);
    xfer_byte(ofs, 1'h1, r, a1);
    start_cond();
    xfer_byte({dev, 1'h1}, 1'h1, r, a2);
    xfer_byte(8'hff, 1'h1, d, a3);
    stop_cond();
    ok = !(a0 | a1 | a2);
  endtask : read_reg

  // two-byte read, first byte acked so a second byte follows from the next offset
  task automatic read_pair(input logic [6:0] dev, input logic [7:0] ofs,
                           output logic [7:0] d0, output logic [7:0] d1,
                           output logic ok);
    logic [7:0] r;
    logic a0, a1, a2, a3, a4;
    start_cond();
    xfer_byte({dev, 1'h0}, 1'h1, r, a0);
    xfer_byte(ofs, 1'h1, r, a1);
    start_cond();
    xfer_byte({dev, 1'h1}, 1'h1, r, a2);
    xfer_byte(8'hff, 1'h0, d0, a3);
    xfer_byte(8'hff, 1'h1, d1, a4);
    stop_cond();
    ok = !(a0 | a1 | a2);
  endtask : read_pair
endmodule : irb_host_model

/* bench/testbench.sv */
// self-checking bench for the route and battery sense register bank
// assumes the host model drives the serial bus; data line pulled up
`timescale 1ns/10ps
module testbench;
  import irb_pkg::*;
  logic clock;
  logic reset_n;
  logic battery_sense_pin_a;
  logic battery_sense_pin_b;
  logic scl, host_sda, sda_wire, sda_out, sda_oe, irq, ok;
  logic [7:0] rd;
  irb_route_t route;
  irb_sense_ctrl_t ctrl_a, ctrl_b;
  int error_cnt = 0;
  int check_count = 0;

  // clock and wired-and data line
  initial
  begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  assign sda_wire = host_sda & ~(sda_oe & ~sda_out);

  irb_host_model u_host (.clock(clock), .sda_wire(sda_wire),
    .scl_drv(scl), .sda_drv(host_sda));
  irb_ctrl u_dut (.clock(clock), .reset_n(reset_n), .scl_pin(scl),
    .sda_pin_in(sda_wire), .sda_pin_out(sda_out), .sda_pin_oe(sda_oe),
    .battery_sense_pin_a(battery_sense_pin_a),
    .battery_sense_pin_b(battery_sense_pin_b), .route_q(route),
    .sense_a_ctrl_q(ctrl_a), .sense_b_ctrl_q(ctrl_b),
    .interrupt_request_pin(irq));

  // shared compare and verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // acknowledged write and masked read-back
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    u_host.write_reg(IRB_DEV_ADDR, ofs, d, ok);
    check({7'h0, ok}, 8'h01);
  endtask : wr
  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] mask,
                        input logic [7:0] exp);
    u_host.read_reg(IRB_DEV_ADDR, ofs, rd, ok);
    check({7'h0, ok}, 8'h01);
    check(rd & mask, exp);
  endtask : rd_chk

  // reset values at the ports and over the bus
  task automatic test_reset();
    check({2'h0, route}, {2'h0, IRB_VID_CVBS, IRB_PD_ONLY1});
    check({4'h0, ctrl_a}, 8'h0b);
    check({4'h0, ctrl_b}, 8'h0b);
    check({7'h0, irq}, 8'h00);
    rd_chk(IRB_OFS_INPUT_FORMAT_SELECT, 8'h1f, 8'h00);
    rd_chk(IRB_OFS_DIAG_PIN_A_CONTROL, 8'h5c, 8'h4c);
    rd_chk(IRB_OFS_DIAG_PIN_B_CONTROL, 8'h5c, 8'h4c);
  endtask : test_reset

  // one pin: power up, trip, read status, clear, power down
  task automatic event_pin(input logic [7:0] ofs, input logic [1:0] m);
    wr(ofs, 8'h0c);
    {battery_sense_pin_b, battery_sense_pin_a} <= m;
    u_host.hwait(10);
    check({7'h0, irq}, 8'h01);
    rd_chk(IRB_OFS_SENSE_STATUS, 8'h03, {6'h0, m});
    {battery_sense_pin_b, battery_sense_pin_a} <= 2'h0;
    wr(IRB_OFS_SENSE_STATUS, {6'h0, m});
    u_host.hwait(4);
    check({7'h0, irq}, 8'h00);
    wr(ofs, 8'h4c);
  endtask : event_pin

  // events ignored while powered down, then each pin alone
  task automatic test_events();
    {battery_sense_pin_b, battery_sense_pin_a} <= 2'h3;
    u_host.hwait(10);
    check({7'h0, irq}, 8'h00);
    rd_chk(IRB_OFS_SENSE_STATUS, 8'h03, 8'h00);
    {battery_sense_pin_b, battery_sense_pin_a} <= 2'h0;
    event_pin(IRB_OFS_DIAG_PIN_A_CONTROL, 2'h1);
    event_pin(IRB_OFS_DIAG_PIN_B_CONTROL, 2'h2);
  endtask : test_events

  // every documented code back to back; reserved codes never written
  task automatic test_formats();
    logic [4:0] codes [8] = '{IRB_CODE_CVBS1, IRB_CODE_CVBS2,
      IRB_CODE_CVBS3, IRB_CODE_CVBS4, IRB_CODE_YC12, IRB_CODE_YC34,
      IRB_CODE_DIFF12, IRB_CODE_DIFF34};
    logic [5:0] routes [8] = '{{IRB_VID_CVBS, IRB_PD_ONLY1},
      {IRB_VID_CVBS, IRB_PD_ONLY2}, {IRB_VID_CVBS, IRB_PD_ONLY3},
      {IRB_VID_CVBS, IRB_PD_ONLY4}, {IRB_VID_YC, IRB_PD_PAIR12},
      {IRB_VID_YC, IRB_PD_PAIR34}, {IRB_VID_DIFF, IRB_PD_PAIR12},
      {IRB_VID_DIFF, IRB_PD_PAIR34}};
    for (int i = 0; i < 8; i++)
    begin
      wr(IRB_OFS_INPUT_FORMAT_SELECT, {3'h0, codes[i]});
      u_host.hwait(4);
      check({2'h0, route}, {2'h0, routes[i]});
      rd_chk(IRB_OFS_INPUT_FORMAT_SELECT, 8'h1f, {3'h0, codes[i]});
    end
  endtask : test_formats

  // foreign device address and unmapped offset
  task automatic test_refused();
    u_host.write_reg(7'h21, IRB_OFS_INPUT_FORMAT_SELECT, 8'h01, ok);
    check({7'h0, ok}, 8'h00);
    rd_chk(IRB_OFS_INPUT_FORMAT_SELECT, 8'h1f, 8'h11);
    wr(8'h10, 8'h55);
    rd_chk(8'h10, 8'hff, 8'h00);
  endtask : test_refused

  // power up first, then all eight threshold codes
  task automatic test_thresholds(input logic [7:0] ofs, input logic b);
    logic [2:0] c;
    wr(ofs, 8'h0c);
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      wr(ofs, {3'h0, c, 2'h0});
      u_host.hwait(4);
      check({4'h0, b ? ctrl_b : ctrl_a}, {5'h0, c});
      rd_chk(ofs, 8'h5c, {3'h0, c, 2'h0});
    end
    wr(ofs, 8'h4c);
    u_host.hwait(4);
    check({4'h0, b ? ctrl_b : ctrl_a}, 8'h0b);
  endtask : test_thresholds

  // two-byte read with master ack, offset advancing from pin a to pin b
  task automatic test_burst();
    logic [7:0] d0, d1;
    wr(IRB_OFS_DIAG_PIN_B_CONTROL, 8'h10);
    u_host.read_pair(IRB_DEV_ADDR, IRB_OFS_DIAG_PIN_A_CONTROL, d0, d1,
      ok);
    check({7'h0, ok}, 8'h01);
    check(d0 & 8'h5c, 8'h4c);
    check(d1 & 8'h5c, 8'h10);
    wr(IRB_OFS_DIAG_PIN_B_CONTROL, 8'h4c);
    u_host.hwait(4);
    check({4'h0, ctrl_b}, 8'h0b);
  endtask : test_burst

  // main sequence
  initial
  begin
    reset_n <= 1'h0;
    battery_sense_pin_a <= 1'h0;
    battery_sense_pin_b <= 1'h0;
    repeat (16) @(posedge clock);
    reset_n <= 1'h1;
    repeat (12) @(posedge clock);
    test_reset();
    test_burst();
    test_events();
    test_formats();
    test_refused();
    test_thresholds(IRB_OFS_DIAG_PIN_A_CONTROL, 1'h0);
    test_thresholds(IRB_OFS_DIAG_PIN_B_CONTROL, 1'h1);
    give_verdict();
  end

  // watchdog, about 90000 clocks
  initial
  begin
    #360000;
    error_cnt++;
    give_verdict();
  end
endmodule : testbench
